// ### core/sector_buffer_dram_map.sv
// Function
// - Ring fill state readable as empty, low or high.
// - Any change of fill state pulses an input-buffer event.
// - Low means fill below ring words minus margin times 1024.
// - Sector target resets to zero; zero means an open-ended burst.
// - After 0x91, acceptance starts at the next sector boundary.
// - Reaching high during a burst ends it and drops later data.
// - Count of sectors stored in the current burst is readable.
// - Refresh interval chosen by two bits: 624, 608, 576, 480 cycles.
// - Reset map: work area, ring, left and right outputs, reserved.
// - Output areas switch between audio and file-system placement.
// - File-system tables at 0xF6200, identifiers at 0xF7000.
// - Introduction table holds four 16-bit summary words.
// - Directory records are six words each.
// - Directories numbered from 1, root is number 1.
// - File records are six words: address, length, id length, type.
// - Only audio files get file records.
// - Address triple all 0xAA or all 0xBB ends file table.
// - Identifier slots are 64 words, directories then files.
// - Nonzero target also ends the burst when the count reaches it.
`timescale 1ns/1ps
`default_nettype none

module sector_buffer_dram_map (
   // System
   input wire logic clock,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Sector source
   input wire logic sector_start,
   input wire logic word_valid,
   input wire logic [15:0] word_data,
   // Ring drain by the decoder
   input wire logic ring_drain,
   // DRAM side
   output logic dram_wr,
   output sector_buffer_pkg::dram_wr_s dram_req,
   output logic refresh_req,
   // Map outputs
   output logic [19:0] input_ring_last,
   output logic [19:0] left_output_begin,
   output logic [19:0] right_output_begin,
   output logic [19:0] left_output_last,
   output logic [19:0] right_output_last,
   output logic fs_map_active,
   // Events
   output logic fill_event,
   output logic dump_end_event
);

   ////////////////////////////////////////////////////////////////////
   logic [7:0] low_margin_setting;
   logic [7:0] sector_target;
   logic [7:0] accepted_sector_count;
   logic [1:0] refresh_period_select;
   logic map_fs;
   logic dram_16m;
   logic [19:0] fill_words;
   logic [19:0] wr_ptr;
   logic [10:0] word_cnt;
   logic [9:0] refresh_cnt;
   logic [9:0] refresh_limit;
   logic [19:0] ring_words;
   logic [19:0] low_threshold;
   sector_buffer_pkg::fill_e fill_state;
   sector_buffer_pkg::fill_e fill_prev;
   logic fill_seen;
   logic [1:0] evt_sticky;
   sector_buffer_pkg::burst_e burst_state;
   logic take_word;
   logic sector_done;
   logic cmd_start;
   logic [19:0] dir_table_begin;
   logic [19:0] ident_table_begin;

   assign cmd_start = reg_wr && reg_addr == sector_buffer_pkg::OFS_COMMAND &&
      reg_wdata == sector_buffer_pkg::CMD_START_BURST;

   // Ring geometry and threshold
   assign input_ring_last = dram_16m ? sector_buffer_pkg::INPUT_RING_LAST_16M
      : sector_buffer_pkg::INPUT_RING_LAST_4M;
   assign ring_words = input_ring_last - sector_buffer_pkg::INPUT_RING_BEGIN + 20'h00001;
   assign low_threshold = ring_words -
      20'(low_margin_setting) * sector_buffer_pkg::MARGIN_UNIT;

   // Fill classification
   always_comb begin
      if (fill_words == 20'h00000) begin
         fill_state = sector_buffer_pkg::FILL_EMPTY;
      end else if (fill_words < low_threshold) begin
         fill_state = sector_buffer_pkg::FILL_LOW;
      end else begin
         fill_state = sector_buffer_pkg::FILL_HIGH;
      end
   end

   // Output area placement, audio or file-system layout
   always_comb begin
      if (map_fs) begin
         right_output_begin = sector_buffer_pkg::FS_RIGHT_BEGIN;
         right_output_last = sector_buffer_pkg::FS_RIGHT_LAST;
         left_output_begin = sector_buffer_pkg::FS_LEFT_BEGIN;
         left_output_last = sector_buffer_pkg::FS_LEFT_LAST;
      end else begin
         right_output_begin = sector_buffer_pkg::RIGHT_OUTPUT_BEGIN;
         right_output_last = sector_buffer_pkg::RIGHT_OUTPUT_LAST;
         left_output_begin = sector_buffer_pkg::LEFT_OUTPUT_BEGIN;
         left_output_last = sector_buffer_pkg::LEFT_OUTPUT_LAST;
      end
   end
   assign fs_map_active = map_fs;

   // Table placement only; the decoder fills the tables, this block fixes where they sit
   assign dir_table_begin = right_output_begin + sector_buffer_pkg::FS_DIR_TABLE_OFS;
   // Root is directory 1 and owns the first slot; file slots follow all directory slots
   assign ident_table_begin = left_output_begin;

   ////////////////////////////////////////////////////////////////////
   // Host writable settings
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         low_margin_setting <= sector_buffer_pkg::RST_LOW_MARGIN;
         sector_target <= sector_buffer_pkg::RST_TARGET;
         refresh_period_select <= sector_buffer_pkg::RST_REFRESH;
         map_fs <= 1'b0;
         dram_16m <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            sector_buffer_pkg::OFS_LOW_MARGIN: low_margin_setting <= reg_wdata;
            sector_buffer_pkg::OFS_TARGET: sector_target <= reg_wdata;
            sector_buffer_pkg::OFS_REFRESH: refresh_period_select <= reg_wdata[1:0];
            sector_buffer_pkg::OFS_MAP_MODE: begin
               map_fs <= reg_wdata[0];
               dram_16m <= reg_wdata[1];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Burst sequencer: arm on command, start at boundary, stop on high or target
   assign sector_done = take_word && word_cnt == sector_buffer_pkg::SECTOR_WORDS - 11'd1;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         burst_state <= sector_buffer_pkg::BURST_IDLE;
      end else begin
         case (burst_state)
            sector_buffer_pkg::BURST_IDLE, sector_buffer_pkg::BURST_DROP: begin
               if (cmd_start) begin
                  burst_state <= sector_buffer_pkg::BURST_ARMED;
               end
            end
            sector_buffer_pkg::BURST_ARMED: begin
               if (sector_start) begin
                  burst_state <= sector_buffer_pkg::BURST_TAKE;
               end
            end
            sector_buffer_pkg::BURST_TAKE: begin
               if (fill_state == sector_buffer_pkg::FILL_HIGH) begin
                  burst_state <= sector_buffer_pkg::BURST_DROP;
               end else if (sector_done && sector_target != 8'h00 &&
                            accepted_sector_count + 8'h01 == sector_target) begin
                  burst_state <= sector_buffer_pkg::BURST_DROP;
               end
            end
            default: burst_state <= sector_buffer_pkg::BURST_IDLE;
         endcase
      end
   end

   // Dump-end pulses on entry to the drop state
   assign dump_end_event = burst_state == sector_buffer_pkg::BURST_TAKE &&
      (fill_state == sector_buffer_pkg::FILL_HIGH || (sector_done && sector_target != 8'h00 &&
      accepted_sector_count + 8'h01 == sector_target));

   // Boundary word is taken while still armed, otherwise the first sector of each burst would lose its first word
   assign take_word = (burst_state == sector_buffer_pkg::BURST_TAKE ||
      (burst_state == sector_buffer_pkg::BURST_ARMED && sector_start)) && word_valid &&
      fill_state != sector_buffer_pkg::FILL_HIGH;

   ////////////////////////////////////////////////////////////////////
   // Ring write pointer, word and sector counters
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= sector_buffer_pkg::INPUT_RING_BEGIN;
         word_cnt <= 11'd0;
         accepted_sector_count <= 8'h00;
      end else begin
         if (cmd_start) begin
            word_cnt <= 11'd0;
            accepted_sector_count <= 8'h00;
         end else if (take_word) begin
            word_cnt <= sector_done ? 11'd0 : word_cnt + 11'd1;
            if (sector_done) begin
               accepted_sector_count <= accepted_sector_count + 8'h01;
            end
         end
         if (take_word) begin
            wr_ptr <= (wr_ptr == input_ring_last) ? sector_buffer_pkg::INPUT_RING_BEGIN
               : wr_ptr + 20'h00001;
         end
      end
   end

   // DRAM write issue, registered
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dram_wr <= 1'b0;
         dram_req <= '0;
      end else begin
         dram_wr <= take_word;
         if (take_word) begin
            dram_req <= '{addr: wr_ptr, data: word_data};
         end
      end
   end

   // Fill level, written words minus drained words
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fill_words <= 20'h00000;
      end else if (take_word && !(ring_drain && fill_words != 20'h00000)) begin
         fill_words <= fill_words + 20'h00001;
      end else if (!take_word && ring_drain && fill_words != 20'h00000) begin
         fill_words <= fill_words - 20'h00001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Fill change detection; first sample after reset is not an event
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fill_prev <= sector_buffer_pkg::FILL_EMPTY;
         fill_seen <= 1'b0;
      end else begin
         fill_prev <= fill_state;
         fill_seen <= 1'b1;
      end
   end
   assign fill_event = fill_seen && fill_prev != fill_state;

   // Sticky event flags; a new event wins over the read clear
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         evt_sticky <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == 0 && fill_event) || (i == 1 && dump_end_event)) begin
               evt_sticky[i] <= 1'b1;
            end else if (reg_rd && reg_addr == sector_buffer_pkg::OFS_EVENTS) begin
               evt_sticky[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Refresh timer; limit is the longest allowed gap
   always_comb begin
      case (refresh_period_select)
         2'b00: refresh_limit = sector_buffer_pkg::REFRESH_CYC_0;
         2'b01: refresh_limit = sector_buffer_pkg::REFRESH_CYC_1;
         2'b10: refresh_limit = sector_buffer_pkg::REFRESH_CYC_2;
         default: refresh_limit = sector_buffer_pkg::REFRESH_CYC_3;
      endcase
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         refresh_cnt <= 10'd0;
         refresh_req <= 1'b0;
      end else begin
         refresh_req <= refresh_cnt >= refresh_limit - 10'd1;
         refresh_cnt <= (refresh_cnt >= refresh_limit - 10'd1) ? 10'd0 : refresh_cnt + 10'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            sector_buffer_pkg::OFS_FILL_STATE: reg_rdata <= {6'h00, fill_state};
            sector_buffer_pkg::OFS_LOW_MARGIN: reg_rdata <= low_margin_setting;
            sector_buffer_pkg::OFS_ACCEPTED: reg_rdata <= accepted_sector_count;
            sector_buffer_pkg::OFS_TARGET: reg_rdata <= sector_target;
            sector_buffer_pkg::OFS_EVENTS: reg_rdata <= {6'h00, evt_sticky};
            sector_buffer_pkg::OFS_MAP_MODE: reg_rdata <= {6'h00, dram_16m, map_fs};
            sector_buffer_pkg::OFS_REFRESH: reg_rdata <= {6'h00, refresh_period_select};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Assertions
   sequence burst_armed_s;
      burst_state == sector_buffer_pkg::BURST_ARMED;
   endsequence
   sequence boundary_s;
      burst_armed_s ##0 sector_start;
   endsequence

   start_boundary_a: assert property (@(posedge clock) disable iff (!rst_b)
      boundary_s |=> burst_state == sector_buffer_pkg::BURST_TAKE)
      else $error("burst did not start at boundary");
   high_drops_a: assert property (@(posedge clock) disable iff (!rst_b)
      fill_state == sector_buffer_pkg::FILL_HIGH |-> !take_word)
      else $error("word taken while ring high");
   fill_event_a: assert property (@(posedge clock) disable iff (!rst_b)
      fill_seen && $changed(fill_state) |-> fill_event)
      else $error("fill change without event");
   count_step_a: assert property (@(posedge clock) disable iff (!rst_b)
      sector_done && !cmd_start |=> accepted_sector_count == $past(accepted_sector_count) + 8'h01)
      else $error("sector count not advanced");
   ring_wrap_a: assert property (@(posedge clock) disable iff (!rst_b)
      take_word && wr_ptr == input_ring_last |=> wr_ptr == sector_buffer_pkg::INPUT_RING_BEGIN)
      else $error("ring did not wrap");
   refresh_bound_a: assert property (@(posedge clock) disable iff (!rst_b)
      refresh_cnt < refresh_limit)
      else $error("refresh gap exceeded");
   target_end_a: assert property (@(posedge clock) disable iff (!rst_b)
      dump_end_event |=> burst_state == sector_buffer_pkg::BURST_DROP)
      else $error("dump end without drop");
   fs_map_a: assert property (@(posedge clock) disable iff (!rst_b)
      map_fs |-> left_output_begin == sector_buffer_pkg::FS_LEFT_BEGIN &&
      right_output_begin == sector_buffer_pkg::FS_RIGHT_BEGIN)
      else $error("file-system map misplaced");
   low_state_a: assert property (@(posedge clock) disable iff (!rst_b)
      fill_words != 20'h00000 && fill_words < low_threshold |-> fill_state == sector_buffer_pkg::FILL_LOW)
      else $error("low state misreported");
   boundary_take_a: assert property (@(posedge clock) disable iff (!rst_b)
      boundary_s ##0 (word_valid && fill_state != sector_buffer_pkg::FILL_HIGH) |-> take_word)
      else $error("boundary word not taken");
   table_fit_a: assert property (@(posedge clock) disable iff (!rst_b)
      map_fs |-> dir_table_begin + sector_buffer_pkg::RECORD_WORDS <= right_output_last)
      else $error("first table record outside right area");
   ident_slot_a: assert property (@(posedge clock) disable iff (!rst_b)
      map_fs |-> ident_table_begin == sector_buffer_pkg::FS_LEFT_BEGIN && ident_table_begin[5:0] == 6'h00)
      else $error("identifier slots misaligned");

endmodule : sector_buffer_dram_map

`default_nettype wire

// ### core/sector_buffer_pkg.sv
package sector_buffer_pkg;

   // Register offsets on the plain host port
   localparam logic [7:0] OFS_FILL_STATE = 8'h40;
   localparam logic [7:0] OFS_LOW_MARGIN = 8'h41;
   localparam logic [7:0] OFS_COMMAND = 8'h42;
   localparam logic [7:0] OFS_ACCEPTED = 8'h43;
   localparam logic [7:0] OFS_TARGET = 8'h44;
   localparam logic [7:0] OFS_EVENTS = 8'h45;
   localparam logic [7:0] OFS_MAP_MODE = 8'h46;
   localparam logic [7:0] OFS_REFRESH = 8'hA2;

   // Reset values
   localparam logic [7:0] RST_LOW_MARGIN = 8'h00;
   localparam logic [7:0] RST_TARGET = 8'h00;
   localparam logic [1:0] RST_REFRESH = 2'h0;

   // Commands
   localparam logic [7:0] CMD_START_BURST = 8'h91;

   // Fill states
   typedef enum logic [1:0] {
      FILL_EMPTY = 2'b00,
      FILL_LOW = 2'b01,
      FILL_HIGH = 2'b10
   } fill_e;

   // Burst sequencer states
   typedef enum logic [1:0] {
      BURST_IDLE = 2'b00,
      BURST_ARMED = 2'b01,
      BURST_TAKE = 2'b10,
      BURST_DROP = 2'b11
   } burst_e;

   // Default 4Mbit map, word addresses
   localparam logic [19:0] WORKING_AREA_BEGIN = 20'h00000;
   localparam logic [19:0] INPUT_RING_BEGIN = 20'h01000;
   localparam logic [19:0] INPUT_RING_LAST_4M = 20'h19FFF;
   localparam logic [19:0] INPUT_RING_LAST_16M = 20'hF34FF;
   localparam logic [19:0] LEFT_OUTPUT_BEGIN = 20'h1A000;
   localparam logic [19:0] LEFT_OUTPUT_LAST = 20'h280FF;
   localparam logic [19:0] RIGHT_OUTPUT_BEGIN = 20'h28100;
   localparam logic [19:0] RIGHT_OUTPUT_LAST = 20'h361FF;
   // File-system map
   localparam logic [19:0] FS_RIGHT_BEGIN = 20'hF6200;
   localparam logic [19:0] FS_RIGHT_LAST = 20'hF6FFF;
   localparam logic [19:0] FS_LEFT_BEGIN = 20'hF7000;
   localparam logic [19:0] FS_LEFT_LAST = 20'hFFFFF;
   localparam logic [19:0] FS_DIR_TABLE_OFS = 20'h00004;
   localparam logic [19:0] RECORD_WORDS = 20'h00006;
   localparam logic [19:0] IDENT_SLOT_WORDS = 20'h00040;
   localparam logic [19:0] MARGIN_UNIT = 20'h00400;
   localparam logic [7:0] END_MARK_A = 8'hAA;
   localparam logic [7:0] END_MARK_B = 8'hBB;

   // Refresh maximum intervals in cycles
   localparam logic [9:0] REFRESH_CYC_0 = 10'd624;
   localparam logic [9:0] REFRESH_CYC_1 = 10'd608;
   localparam logic [9:0] REFRESH_CYC_2 = 10'd576;
   localparam logic [9:0] REFRESH_CYC_3 = 10'd480;

   // Sector length in words
   localparam logic [10:0] SECTOR_WORDS = 11'd1176;

   // Host register write
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } reg_wr_s;

   // DRAM write request
   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] data;
   } dram_wr_s;

endpackage : sector_buffer_pkg

// ### tb/sector_buffer_dram_map_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sector_buffer_dram_map_tb;
   logic clock, rst_b, reg_wr, reg_rd, sector_start, word_valid, ring_drain, dram_wr, refresh_req;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [15:0] word_data;
   sector_buffer_pkg::dram_wr_s dram_req;
   logic [19:0] input_ring_last, left_output_begin, right_output_begin, left_output_last, right_output_last;
   logic fs_map_active, fill_event, dump_end_event, src_go, src_slow, src_busy;
   logic [3:0] src_n;
   logic [9:0] per [4];
   int n_mismatch, samples_checked, n_wr, n_fill, n_dump, b_wr, b_fill, b_dump, i, k;

   sector_buffer_dram_map dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sector_start(sector_start),
      .word_valid(word_valid), .word_data(word_data), .ring_drain(ring_drain), .dram_wr(dram_wr),
      .dram_req(dram_req), .refresh_req(refresh_req), .input_ring_last(input_ring_last),
      .left_output_begin(left_output_begin), .right_output_begin(right_output_begin),
      .left_output_last(left_output_last), .right_output_last(right_output_last),
      .fs_map_active(fs_map_active), .fill_event(fill_event), .dump_end_event(dump_end_event));

   sector_source src (.clock(clock), .rst_b(rst_b), .start(src_go), .n_sect(src_n), .slow(src_slow),
      .sector_start(sector_start), .word_valid(word_valid), .word_data(word_data), .busy(src_busy));

   ////////////////////////////////////////////////////////////
   // Clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Event and write tallies, compared as differences across each test
   always @(posedge clock) begin
      if (dram_wr === 1'b1) n_wr++;
      if (fill_event === 1'b1) n_fill++;
      if (dump_end_event === 1'b1) n_dump++;
   end

   ////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic give_up(input string what);
      n_mismatch++;
      $display("Error %s expected event seen none", what);
      complete_run;
   endtask : give_up

   // Host port: one-cycle strobes, read data sampled in the following cycle
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic read_check(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      check(what, exp, reg_rdata);
   endtask : read_check

   // Waits up to a bound for a strobe, sampled mid-cycle where outputs are settled
   task automatic wait_hi(input string what, ref logic s, input int lim);
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (s !== 1'b1 && k < lim);
      if (k >= lim) give_up(what);
   endtask : wait_hi

   task automatic run_source(input logic [3:0] n, input logic slow);
      @(posedge clock);
      src_n <= n;
      src_slow <= slow;
      src_go <= 1'b1;
      @(posedge clock);
      src_go <= 1'b0;
   endtask : run_source

   task automatic wait_source;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (src_busy !== 1'b0 && k < 8000);
      if (k >= 8000) give_up("source done");
   endtask : wait_source

   task automatic mark;
      b_wr = n_wr;
      b_fill = n_fill;
      b_dump = n_dump;
   endtask : mark

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {reg_wr, reg_rd, ring_drain, src_go, src_slow, reg_addr, reg_wdata, src_n} = '0;
      per = '{sector_buffer_pkg::REFRESH_CYC_0, sector_buffer_pkg::REFRESH_CYC_1,
              sector_buffer_pkg::REFRESH_CYC_2, sector_buffer_pkg::REFRESH_CYC_3};
      rst_b = 1'b0;
      repeat (5) @(posedge clock);
      @(negedge clock) rst_b = 1'b1;
      // Reset state and map
      check("ring last", 20'h19FFF, input_ring_last);
      check("left begin", 20'h1A000, left_output_begin);
      check("right last", 20'h361FF, right_output_last);
      check("left last", 20'h280FF, left_output_last);
      check("right begin", 20'h28100, right_output_begin);
      check("fs map", 1'b0, fs_map_active);
      read_check("target", sector_buffer_pkg::OFS_TARGET, 8'h00);
      read_check("fill state", sector_buffer_pkg::OFS_FILL_STATE, 8'h00);
      read_check("count", sector_buffer_pkg::OFS_ACCEPTED, 8'h00);
      read_check("unmapped", 8'h47, 8'h00);
      $display("Test reset done");
      // Refresh interval for every code
      for (i = 0; i < 4; i++) begin
         reg_write(sector_buffer_pkg::OFS_REFRESH, 8'(i));
         read_check("refresh select", sector_buffer_pkg::OFS_REFRESH, 8'(i));
         repeat (2) wait_hi("refresh", refresh_req, 1300);
         wait_hi("refresh", refresh_req, 1300);
         check("refresh period", per[i], k);
      end
      $display("Test refresh done");
      // Open burst armed mid-sector, ring high after 1024 words
      reg_write(sector_buffer_pkg::OFS_LOW_MARGIN, 8'h63);
      mark;
      run_source(4'h2, 1'b0);
      repeat (100) @(posedge clock);
      check("early writes", 32'h0, n_wr - b_wr);
      reg_write(sector_buffer_pkg::OFS_COMMAND, sector_buffer_pkg::CMD_START_BURST);
      wait_hi("first write", dram_wr, 2000);
      check("first addr", sector_buffer_pkg::INPUT_RING_BEGIN, dram_req.addr);
      check("first data", 16'h1000, dram_req.data);
      wait_source;
      check("words stored", 32'h400, n_wr - b_wr);
      check("dump ends", 32'h1, n_dump - b_dump);
      check("fill events", 32'h2, n_fill - b_fill);
      read_check("fill state", sector_buffer_pkg::OFS_FILL_STATE, 8'h02);
      read_check("count", sector_buffer_pkg::OFS_ACCEPTED, 8'h00);
      read_check("events", sector_buffer_pkg::OFS_EVENTS, 8'h03);
      read_check("events cleared", sector_buffer_pkg::OFS_EVENTS, 8'h00);
      $display("Test ring high done");
      // Counted burst of two from a slow source offering three
      mark;
      reg_write(sector_buffer_pkg::OFS_LOW_MARGIN, 8'h00);
      read_check("fill state", sector_buffer_pkg::OFS_FILL_STATE, 8'h01);
      reg_write(sector_buffer_pkg::OFS_TARGET, 8'h02);
      read_check("target", sector_buffer_pkg::OFS_TARGET, 8'h02);
      reg_write(sector_buffer_pkg::OFS_COMMAND, sector_buffer_pkg::CMD_START_BURST);
      run_source(4'h3, 1'b1);
      wait_hi("first write", dram_wr, 2000);
      check("next addr", 20'h01400, dram_req.addr);
      wait_source;
      check("words stored", 32'h930, n_wr - b_wr);
      check("dump ends", 32'h1, n_dump - b_dump);
      check("fill events", 32'h1, n_fill - b_fill);
      read_check("count", sector_buffer_pkg::OFS_ACCEPTED, 8'h02);
      $display("Test target done");
      // Drain to empty; fill state is read only
      mark;
      @(posedge clock) ring_drain <= 1'b1;
      repeat (3400) @(posedge clock);
      ring_drain <= 1'b0;
      reg_write(sector_buffer_pkg::OFS_FILL_STATE, 8'h02);
      read_check("fill state", sector_buffer_pkg::OFS_FILL_STATE, 8'h00);
      check("fill events", 32'h1, n_fill - b_fill);
      $display("Test drain done");
      // Map switching
      reg_write(sector_buffer_pkg::OFS_MAP_MODE, 8'h01);
      repeat (2) @(posedge clock);
      check("fs map", 1'b1, fs_map_active);
      check("fs left", sector_buffer_pkg::FS_LEFT_BEGIN, left_output_begin);
      check("fs right", sector_buffer_pkg::FS_RIGHT_BEGIN, right_output_begin);
      check("fs right last", sector_buffer_pkg::FS_RIGHT_LAST, right_output_last);
      check("fs left last", sector_buffer_pkg::FS_LEFT_LAST, left_output_last);
      reg_write(sector_buffer_pkg::OFS_MAP_MODE, 8'h02);
      repeat (2) @(posedge clock);
      check("big ring", sector_buffer_pkg::INPUT_RING_LAST_16M, input_ring_last);
      check("fs map", 1'b0, fs_map_active);
      reg_write(sector_buffer_pkg::OFS_MAP_MODE, 8'h00);
      repeat (2) @(posedge clock);
      check("audio left", sector_buffer_pkg::LEFT_OUTPUT_BEGIN, left_output_begin);
      $display("Test map done");
      complete_run;
   end
endmodule : sector_buffer_dram_map_tb

`default_nettype wire

// ### tb/sector_source.sv
`timescale 1ns/1ps
`default_nettype none

module sector_source (
   // System
   input wire logic clock,
   input wire logic rst_b,
   // Request from the bench
   input wire logic start,
   input wire logic [3:0] n_sect,
   input wire logic slow,
   // Sector stream
   output logic sector_start,
   output logic word_valid,
   output logic [15:0] word_data,
   output logic busy
);
   logic [3:0] sec;
   logic [11:0] widx;
   logic phase;
   logic emit;

   ////////////////////////////////////////////////////////////
   // Slow mode offers a word every other cycle only
   assign emit = busy & (~slow | phase);

   // Whole sectors back to back; the host arms the device mid-stream, ahead of the wanted one
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busy <= 1'b0;
         sec <= 4'h0;
         widx <= 12'h000;
         phase <= 1'b0;
         word_valid <= 1'b0;
         sector_start <= 1'b0;
         word_data <= 16'h0000;
      end else begin
         phase <= busy & slow & ~phase;
         word_valid <= emit;
         sector_start <= emit & (widx == 12'h000);
         // Idle data keeps toggling so that a stale word is never mistaken for a real one
         word_data <= emit ? {sec, widx} : ~word_data;
         if (start && !busy) begin
            busy <= 1'b1;
            sec <= 4'h0;
            widx <= 12'h000;
         end else if (emit) begin
            if (widx == 12'h497) begin
               widx <= 12'h000;
               sec <= sec + 4'h1;
               busy <= (sec + 4'h1) != n_sect;
            end else begin
               widx <= widx + 12'h001;
            end
         end
      end
   end
endmodule : sector_source

`default_nettype wire
